/* rtl/ssr_pkg.sv */
// Constants, timing and carrier types for the strobed static RAM host controller
`default_nettype none
//------------------------------------------------------------
// Functional notes
//------------------------------------------------------------
package ssr_pkg;
    //------------------------------------------------------------
    // Geometry and clock
    //------------------------------------------------------------
    localparam int ADDR_W = 10;     // 1024 single-bit words
    localparam int CLK_NS = 10;     // 100 MHz system clock
    localparam int SYNC_CYC = 3;    // Margin for the two-stage pin synchroniser
    localparam int PWRUP_NS = 1000; // Strobe held steady after reset

    //------------------------------------------------------------
    // Device timing in ns, commercial grade
    //------------------------------------------------------------
    localparam int COM_LOW_NS = 130;  // Strobe low minimum
    localparam int COM_HIGH_NS = 125; // Strobe high minimum
    localparam int COM_WP_NS = 130;   // Write pulse minimum
    localparam int COM_DS_NS = 140;   // Data set-up before end of write
    localparam int COM_CYC_NS = 255;  // Cycle time minimum
    localparam int COM_ACS_NS = 225;  // Access from strobe maximum
    // Military grade
    localparam int MIL_LOW_NS = 150;
    localparam int MIL_HIGH_NS = 140;
    localparam int MIL_WP_NS = 150;
    localparam int MIL_DS_NS = 150;
    localparam int MIL_CYC_NS = 290;
    localparam int MIL_ACS_NS = 250;
    // Both grades
    localparam int AS_NS = 15; // Address set-up before strobe fall

    //------------------------------------------------------------
    // Helpers
    //------------------------------------------------------------
    // Least time rounded up to whole cycles, at least one
    function automatic int cyc_up(input int ns);
        int c;
        c = (ns + CLK_NS - 1) / CLK_NS;
        return (c < 1) ? 1 : c;
    endfunction : cyc_up

    // Larger of two
    function automatic int imax(input int a, input int b);
        return (a > b) ? a : b;
    endfunction : imax

    //------------------------------------------------------------
    // Types
    //------------------------------------------------------------
    typedef logic [7:0] ssr_cnt_t; // Phase length in cycles

    // Pins toward the memory
    typedef struct packed {
        logic strobe_select_n;
        logic second_select_n;
        logic third_select_n;
        logic we_n;
        logic [ADDR_W-1:0] addr;
        logic bit_input;
        logic bit_input_oe;
    } ssr_pins_s;

    // User request
    typedef struct packed {
        logic write;
        logic [ADDR_W-1:0] addr;
        logic data;
    } ssr_req_s;

    // Phase lengths of one grade
    typedef struct packed {
        ssr_cnt_t setup;
        ssr_cnt_t rd_low;
        ssr_cnt_t wr_low;
        ssr_cnt_t rd_high;
        ssr_cnt_t wr_high;
    } ssr_tim_s;

    // Controller states
    typedef enum logic [2:0] {
        ST_PWRUP = 3'h0,
        ST_IDLE = 3'h1,
        ST_SETUP = 3'h2,
        ST_LOW = 3'h3,
        ST_HIGH = 3'h4
    } ssr_state_e;

    //------------------------------------------------------------
    // Derived cycle counts
    //------------------------------------------------------------
    localparam int SETUP_C = cyc_up(AS_NS);
    localparam int PWRUP_C = cyc_up(PWRUP_NS);
    localparam int COM_RDL_C = imax(cyc_up(COM_LOW_NS), cyc_up(COM_ACS_NS) + SYNC_CYC);
    localparam int COM_WRL_C = imax(cyc_up(COM_LOW_NS), imax(cyc_up(COM_WP_NS),
                                                             cyc_up(COM_DS_NS)));
    localparam int MIL_RDL_C = imax(cyc_up(MIL_LOW_NS), cyc_up(MIL_ACS_NS) + SYNC_CYC);
    localparam int MIL_WRL_C = imax(cyc_up(MIL_LOW_NS), imax(cyc_up(MIL_WP_NS),
                                                             cyc_up(MIL_DS_NS)));

    localparam ssr_tim_s TIM_COM = '{
        setup: ssr_cnt_t'(SETUP_C),
        rd_low: ssr_cnt_t'(COM_RDL_C),
        wr_low: ssr_cnt_t'(COM_WRL_C),
        rd_high: ssr_cnt_t'(imax(cyc_up(COM_HIGH_NS), cyc_up(COM_CYC_NS) - COM_RDL_C - SETUP_C)),
        wr_high: ssr_cnt_t'(imax(cyc_up(COM_HIGH_NS), cyc_up(COM_CYC_NS) - COM_WRL_C - SETUP_C))
    };
    localparam ssr_tim_s TIM_MIL = '{
        setup: ssr_cnt_t'(SETUP_C),
        rd_low: ssr_cnt_t'(MIL_RDL_C),
        wr_low: ssr_cnt_t'(MIL_WRL_C),
        rd_high: ssr_cnt_t'(imax(cyc_up(MIL_HIGH_NS), cyc_up(MIL_CYC_NS) - MIL_RDL_C - SETUP_C)),
        wr_high: ssr_cnt_t'(imax(cyc_up(MIL_HIGH_NS), cyc_up(MIL_CYC_NS) - MIL_WRL_C - SETUP_C))
    };
endpackage : ssr_pkg
`default_nettype wire

/* rtl/ssr_timer.sv */
// Phase down-counter for the strobed static RAM host controller
`default_nettype none
module ssr_timer (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Load request
    input wire logic i_load,
    input wire ssr_pkg::ssr_cnt_t i_count,
    // Status
    output logic o_zero
);
    //------------------------------------------------------------
    // Counter
    //------------------------------------------------------------
    ssr_pkg::ssr_cnt_t cnt_r;   // Cycles left minus one
    ssr_pkg::ssr_cnt_t cnt_nxt; // Next count

    // Load gives exactly i_count cycles until zero is left
    always_comb begin
        if (i_load) begin
            cnt_nxt = i_count - ssr_pkg::ssr_cnt_t'(1);
        end else if (cnt_r != '0) begin
            cnt_nxt = cnt_r - ssr_pkg::ssr_cnt_t'(1);
        end else begin
            cnt_nxt = cnt_r;
        end
    end

    // Register; reset starts the power-up hold
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cnt_r <= ssr_pkg::ssr_cnt_t'(ssr_pkg::PWRUP_C - 1);
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    // Phase finished
    assign o_zero = (cnt_r == '0);
endmodule : ssr_timer
`default_nettype wire

/* rtl/ssr_host.sv */
// Host controller driving a strobed 1024 x 1 static RAM through its pins
`default_nettype none
module ssr_host (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // User request
    input wire logic i_req_valid,
    input wire ssr_pkg::ssr_req_s i_req,
    output logic o_req_ready,
    // User answer
    output logic o_done,
    output logic o_refused,
    output logic o_rd_data,
    // Modes
    input wire logic i_mil_grade,
    input wire logic i_retention,
    // Memory pins
    output ssr_pkg::ssr_pins_s o_pins,
    input wire logic i_data_out
);
    //------------------------------------------------------------
    // Pin synchroniser
    //------------------------------------------------------------
    logic dout_s1_r; // First stage, read only by second
    logic dout_s2_r; // Safe copy of the data pin

    // Two flops before any logic
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            dout_s1_r <= 1'b0;
            dout_s2_r <= 1'b0;
        end else begin
            dout_s1_r <= i_data_out;
            dout_s2_r <= dout_s1_r;
        end
    end

    //------------------------------------------------------------
    // Controller state
    //------------------------------------------------------------
    ssr_pkg::ssr_state_e state_r, state_nxt; // Phase
    ssr_pkg::ssr_pins_s pins_r, pins_nxt;    // Registered pins
    ssr_pkg::ssr_req_s req_r, req_nxt;       // Request in progress
    logic mil_r, mil_nxt;                    // Grade of this access
    logic ready_r, ready_nxt;                // Accepting requests
    logic done_r, done_nxt;                  // End of access pulse
    logic refused_r, refused_nxt;            // Write refused pulse
    logic rdata_r, rdata_nxt;                // Last read bit
    logic t_load;                            // Timer load
    ssr_pkg::ssr_cnt_t t_count;              // Timer length
    logic t_zero;                            // Phase over
    ssr_pkg::ssr_tim_s tim;                  // Lengths of grade in use

    // Phase timer
    ssr_timer u_timer (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_load(t_load),
        .i_count(t_count),
        .o_zero(t_zero)
    );

    // Grade table
    always_comb begin
        tim = mil_r ? ssr_pkg::TIM_MIL : ssr_pkg::TIM_COM;
    end

    // Next-state logic
    always_comb begin
        state_nxt = state_r;
        pins_nxt = pins_r;
        req_nxt = req_r;
        mil_nxt = mil_r;
        ready_nxt = ready_r;
        done_nxt = 1'b0;
        refused_nxt = 1'b0;
        rdata_nxt = rdata_r;
        t_load = 1'b0;
        t_count = tim.setup;
        unique case (state_r)
            // Strobe held high while supply and lines settle
            ssr_pkg::ST_PWRUP: begin
                if (t_zero) begin
                    state_nxt = ssr_pkg::ST_IDLE;
                    ready_nxt = 1'b1;
                end
            end
            // Wait for a request
            ssr_pkg::ST_IDLE: begin
                if (i_req_valid && ready_r) begin
                    if (i_req.write && i_retention) begin
                        refused_nxt = 1'b1;
                    end else begin
                        req_nxt = i_req;
                        mil_nxt = i_mil_grade;
                        ready_nxt = 1'b0;
                        state_nxt = ssr_pkg::ST_SETUP;
                        t_load = 1'b1;
                        t_count = i_mil_grade ? ssr_pkg::TIM_MIL.setup
                                              : ssr_pkg::TIM_COM.setup;
                        // Address set up ahead of the strobe fall
                        pins_nxt.addr = i_req.addr;
                        pins_nxt.bit_input = i_req.data;
                        // Drive data only for writes, shared line stays free
                        pins_nxt.bit_input_oe = i_req.write;
                    end
                end
            end
            // Address set-up, then all selects fall together
            ssr_pkg::ST_SETUP: begin
                if (t_zero) begin
                    state_nxt = ssr_pkg::ST_LOW;
                    t_load = 1'b1;
                    t_count = req_r.write ? tim.wr_low : tim.rd_low;
                    pins_nxt.strobe_select_n = 1'b0;
                    // Joined selects suit both the single- and three-select part
                    pins_nxt.second_select_n = 1'b0;
                    pins_nxt.third_select_n = 1'b0;
                    pins_nxt.we_n = ~req_r.write;
                end
            end
            // Selects low; data and address held throughout
            ssr_pkg::ST_LOW: begin
                if (t_zero) begin
                    state_nxt = ssr_pkg::ST_HIGH;
                    t_load = 1'b1;
                    t_count = req_r.write ? tim.wr_high : tim.rd_high;
                    // All rise together, data released with them
                    pins_nxt.strobe_select_n = 1'b1;
                    pins_nxt.second_select_n = 1'b1;
                    pins_nxt.third_select_n = 1'b1;
                    pins_nxt.we_n = 1'b1;
                    pins_nxt.bit_input_oe = 1'b0;
                    if (!req_r.write) begin
                        rdata_nxt = dout_s2_r;
                    end
                end
            end
            // Recovery before the next strobe
            ssr_pkg::ST_HIGH: begin
                if (t_zero) begin
                    state_nxt = ssr_pkg::ST_IDLE;
                    ready_nxt = 1'b1;
                    done_nxt = 1'b1;
                end
            end
            // Illegal codes return to a safe idle
            default: begin
                state_nxt = ssr_pkg::ST_IDLE;
                ready_nxt = 1'b1;
            end
        endcase
    end

    // Registers; reset parks selects and we_n high, address and data low, data line released
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_r <= ssr_pkg::ST_PWRUP;
            pins_r <= '{strobe_select_n: 1'b1, second_select_n: 1'b1,
                        third_select_n: 1'b1, we_n: 1'b1, default: '0};
            req_r <= '0;
            mil_r <= 1'b0;
            ready_r <= 1'b0;
            done_r <= 1'b0;
            refused_r <= 1'b0;
            rdata_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            pins_r <= pins_nxt;
            req_r <= req_nxt;
            mil_r <= mil_nxt;
            ready_r <= ready_nxt;
            done_r <= done_nxt;
            refused_r <= refused_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // Outputs straight from flops
    assign o_pins = pins_r;
    assign o_req_ready = ready_r;
    assign o_done = done_r;
    assign o_refused = refused_r;
    assign o_rd_data = rdata_r;

    //------------------------------------------------------------
    // Assertion helpers
    //------------------------------------------------------------
    logic [8:0] low_cnt_r;  // Cycles strobe has been low
    logic [8:0] high_cnt_r; // Cycles strobe has been high
    logic [8:0] per_cnt_r;  // Cycles since last strobe fall
    logic [8:0] we_cnt_r;   // Cycles write-enable has been low
    int min_low, min_high, min_wp, min_cyc;

    // Grade minimums in cycles
    always_comb begin
        min_low = mil_r ? ssr_pkg::cyc_up(ssr_pkg::MIL_LOW_NS)
                        : ssr_pkg::cyc_up(ssr_pkg::COM_LOW_NS);
        min_high = mil_r ? ssr_pkg::cyc_up(ssr_pkg::MIL_HIGH_NS)
                         : ssr_pkg::cyc_up(ssr_pkg::COM_HIGH_NS);
        min_wp = mil_r ? ssr_pkg::cyc_up(ssr_pkg::MIL_WP_NS)
                       : ssr_pkg::cyc_up(ssr_pkg::COM_WP_NS);
        min_cyc = mil_r ? ssr_pkg::cyc_up(ssr_pkg::MIL_CYC_NS)
                        : ssr_pkg::cyc_up(ssr_pkg::COM_CYC_NS);
    end

    // Saturating width counters on the registered pins
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            low_cnt_r <= '0;
            high_cnt_r <= 9'h1FF;
            per_cnt_r <= 9'h1FF;
            we_cnt_r <= '0;
        end else begin
            low_cnt_r <= pins_r.strobe_select_n ? 9'h000 : low_cnt_r + {8'h00, ~&low_cnt_r};
            high_cnt_r <= !pins_r.strobe_select_n ? 9'h000
                                                 : high_cnt_r + {8'h00, ~&high_cnt_r};
            per_cnt_r <= (pins_nxt.strobe_select_n == 1'b0 && pins_r.strobe_select_n)
                         ? 9'h000 : per_cnt_r + {8'h00, ~&per_cnt_r};
            we_cnt_r <= pins_r.we_n ? 9'h000 : we_cnt_r + {8'h00, ~&we_cnt_r};
        end
    end

    //------------------------------------------------------------
    // Assertions
    //------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    strobe_low_min_a: assert property (
        $rose(o_pins.strobe_select_n) |-> int'(low_cnt_r) >= min_low)
        else $error("strobe low too short");
    strobe_high_min_a: assert property (
        $fell(o_pins.strobe_select_n) |-> int'(high_cnt_r) >= min_high)
        else $error("strobe high too short");
    write_pulse_min_a: assert property (
        $rose(o_pins.we_n) |-> int'(we_cnt_r) >= min_wp)
        else $error("write pulse too short");
    // Counter clears at the fall edge itself, so the span is read one cycle back
    cycle_spacing_a: assert property (
        $fell(o_pins.strobe_select_n) |-> int'($past(per_cnt_r)) + 1 >= min_cyc)
        else $error("strobe cycles too close");
    read_margin_a: assert property (
        $rose(o_pins.strobe_select_n) && $past(o_pins.we_n) |-> int'(low_cnt_r) > min_low)
        else $error("read select not held beyond minimum");
    wr_data_hold_a: assert property (
        !o_pins.we_n |-> o_pins.bit_input_oe && $stable(o_pins.bit_input))
        else $error("write data changed during write");
    read_no_drive_a: assert property (
        !o_pins.strobe_select_n && o_pins.we_n |-> !o_pins.bit_input_oe)
        else $error("data driven during read");
    retention_refuse_a: assert property (
        o_refused |-> o_pins.we_n [*8])
        else $error("write issued during retention");
    pwrup_steady_a: assert property (
        state_r == ssr_pkg::ST_PWRUP |-> o_pins.strobe_select_n && $stable(o_pins.strobe_select_n))
        else $error("strobe moved during power-up");
    selects_joined_a: assert property (
        o_pins.second_select_n == o_pins.strobe_select_n
        && o_pins.third_select_n == o_pins.strobe_select_n)
        else $error("selects not moving together");

    read_cycle_c: cover property ($rose(o_pins.strobe_select_n) && $past(o_pins.we_n));
    write_cycle_c: cover property ($rose(o_pins.we_n));
    refused_c: cover property (o_refused);
    back_to_back_c: cover property (o_done ##1 (i_req_valid && o_req_ready));
endmodule : ssr_host
`default_nettype wire

/* tb/ssr_mem_model.sv */
// Behavioural model of the strobed 1024 x 1 static RAM seen by the host controller
`default_nettype none
module ssr_mem_model (
    // Grade and supply state of the part
    input wire logic i_mil,
    input wire logic i_ret,
    // Pins from the host
    input wire ssr_pkg::ssr_pins_s i_pins,
    // Data pin back to the host
    output logic o_data_out,
    // Slip and strobe counters
    output int o_viol,
    output int o_falls
);
    timeunit 1ns;
    timeprecision 100ps;
    logic mem [0:1023]; // One bit per location
    logic [9:0] lat_r; // Address latch
    logic out_r; // Output register
    logic acc_ok; // Access time from strobe fall has run out
    logic fell_r; // Latch loaded for this strobe
    logic wr_seen; // This strobe carried a write
    logic last_v; // Last driven level
    time t_fall, t_rise, t_wfall, t_data;
    wire logic strb = i_pins.strobe_select_n;
    // Output enable ignores the strobe
    wire logic out_en = !i_pins.second_select_n && !i_pins.third_select_n && i_pins.we_n;
    wire logic wr_act = !strb && !i_pins.second_select_n && !i_pins.third_select_n && !i_pins.we_n;

    // Counters start clear
    initial begin
        o_viol = 0;
        o_falls = 0;
        fell_r = 1'b0;
        wr_seen = 1'b0;
        acc_ok = 1'b0;
        last_v = 1'b0;
        t_rise = 0;
    end

    // Counts one host slip
    task automatic slip(input bit bad);
        if (bad) o_viol = o_viol + 1;
    endtask : slip

    // Strobe fall: latch address, check spacing
    always @(negedge strb) begin
        lat_r = i_pins.addr;
        slip(o_falls > 0 && $time - t_fall <
             (i_mil ? ssr_pkg::MIL_CYC_NS : ssr_pkg::COM_CYC_NS));
        slip($time - t_rise < (i_mil ? ssr_pkg::MIL_HIGH_NS : ssr_pkg::COM_HIGH_NS));
        o_falls = o_falls + 1;
        t_fall = $time;
        wr_seen = 1'b0;
        acc_ok = 1'b0;
        fell_r = 1'b1;
        acc_ok <= #(i_mil ? ssr_pkg::MIL_ACS_NS : ssr_pkg::COM_ACS_NS) 1'b1;
    end

    // Strobe rise: load output register, check widths
    always @(posedge strb) begin
        if (o_falls > 0) begin
            slip($time - t_fall < (i_mil ? ssr_pkg::MIL_LOW_NS : ssr_pkg::COM_LOW_NS));
            slip(!wr_seen && $time - t_fall <
                 (i_mil ? ssr_pkg::MIL_ACS_NS : ssr_pkg::COM_ACS_NS));
        end
        out_r = mem[lat_r];
        t_rise = $time;
        fell_r = 1'b0;
        acc_ok = 1'b0;
    end

    // Level store; value just before the first rising select or we_n stays
    always @* begin
        if (wr_act && fell_r) begin
            mem[lat_r] = i_pins.bit_input;
            wr_seen = 1'b1;
            slip(i_ret);
        end
    end

    // Write pulse and data set-up
    always @(negedge i_pins.we_n) t_wfall = $time;
    always @(i_pins.bit_input) t_data = $time;
    always @(posedge i_pins.we_n) begin
        if (wr_seen) begin
            slip($time - t_wfall < (i_mil ? ssr_pkg::MIL_WP_NS : ssr_pkg::COM_WP_NS));
            slip($time - t_data < (i_mil ? ssr_pkg::MIL_DS_NS : ssr_pkg::COM_DS_NS));
        end
    end

    // Data pin: inverse of last level when released, unsettled before access
    always @* begin
        if (!out_en) begin
            o_data_out = ~last_v;
        end else begin
            if (!strb) o_data_out = acc_ok ? mem[lat_r] : ~mem[lat_r];
            else o_data_out = out_r;
            last_v = o_data_out;
        end
    end
endmodule : ssr_mem_model
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench of the strobed static RAM host controller
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic i_clk, i_rst, req_valid, mil, ret;
    ssr_pkg::ssr_req_s req;
    logic ready, done, refused, rd_data, dout;
    ssr_pkg::ssr_pins_s pins;
    int viol, falls, bad_count, tests_run;

    ssr_host uut (.i_clk(i_clk), .i_rst(i_rst), .i_req_valid(req_valid), .i_req(req),
        .o_req_ready(ready), .o_done(done), .o_refused(refused), .o_rd_data(rd_data),
        .i_mil_grade(mil), .i_retention(ret), .o_pins(pins), .i_data_out(dout));
    ssr_mem_model mem_m (.i_mil(mil), .i_ret(ret), .i_pins(pins), .o_data_out(dout),
        .o_viol(viol), .o_falls(falls));

    // 100 MHz clock
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    // Compare and count
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Counts, verdict, end of run
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : give_verdict

    // One access: hold valid until taken, check pins in the low phase
    task automatic do_acc(input logic wr, input logic [9:0] a, input logic d, input logic refuse);
        int n;
        int f0;
        @(posedge i_clk);
        req_valid <= 1'b1;
        req <= '{write: wr, addr: a, data: d};
        n = 0;
        do begin @(negedge i_clk); n++; end while (ready !== 1'b1 && n < 300);
        @(posedge i_clk);
        req_valid <= 1'b0;
        f0 = falls;
        n = 0;
        if (refuse) begin
            do begin @(negedge i_clk); n++; end while (refused !== 1'b1 && n < 3);
            check("refused", refused, 1'b1);
            check("ready after refuse", ready, 1'b1);
            repeat (40) @(negedge i_clk);
            check("strobe count", 16'(falls - f0), 16'h0000);
        end else begin
            do begin @(negedge i_clk); n++; end while (pins.strobe_select_n !== 1'b0 && n < 10);
            check("selects", {pins.strobe_select_n, pins.second_select_n,
                pins.third_select_n}, 3'h0);
            check("we_n", pins.we_n, !wr);
            check("oe", pins.bit_input_oe, wr);
            check("addr", pins.addr, a);
            if (wr) check("bit_input", pins.bit_input, d);
            do begin @(negedge i_clk); n++; end while (done !== 1'b1 && n < 100);
            check("done", done, 1'b1);
            @(negedge i_clk);
            check("done pulse", done, 1'b0);
        end
    endtask : do_acc

    // Read and compare the returned bit
    task automatic rd_chk(input logic [9:0] a, input logic exp);
        do_acc(1'b0, a, 1'b0, 1'b0);
        check("rd_data", rd_data, exp);
    endtask : rd_chk

    // Strobe held high and steady after reset
    task automatic t_pwrup();
        int n;
        n = 0;
        do begin @(negedge i_clk); n++; end while (ready !== 1'b1 && n < 300);
        check("pwrup ready", ready, 1'b1);
        check("pwrup hold", n >= ssr_pkg::PWRUP_C, 1'b1);
        check("pwrup strobe", 16'(falls), 16'h0000);
    endtask : t_pwrup

    // Both polarities at edge and middle addresses, back to back
    task automatic t_rw();
        logic [9:0] adr [4] = '{10'h000, 10'h3FF, 10'h001, 10'h200};
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < 4; i++) do_acc(1'b1, adr[i], 1'((i + p) % 2), 1'b0);
            for (int i = 0; i < 4; i++) rd_chk(adr[i], 1'((i + p) % 2));
        end
    endtask : t_rw

    // Military grade timing on writes and reads
    task automatic t_mil();
        @(posedge i_clk);
        mil <= 1'b1;
        do_acc(1'b1, 10'h155, 1'b1, 1'b0);
        do_acc(1'b1, 10'h2AA, 1'b0, 1'b0);
        rd_chk(10'h155, 1'b1);
        rd_chk(10'h2AA, 1'b0);
        @(posedge i_clk);
        mil <= 1'b0;
    endtask : t_mil

    // Write refused on retention supply, location keeps its bit
    task automatic t_ret();
        @(posedge i_clk);
        ret <= 1'b1;
        do_acc(1'b1, 10'h000, 1'b0, 1'b1);
        @(posedge i_clk);
        ret <= 1'b0;
        rd_chk(10'h000, 1'b1);
    endtask : t_ret

    // Main sequence
    initial begin
        i_rst = 1'b1;
        req_valid = 1'b0;
        req = '0;
        mil = 1'b0;
        ret = 1'b0;
        bad_count = 0;
        tests_run = 0;
        repeat (3) @(posedge i_clk);
        #1;
        check("reset pins", {pins.strobe_select_n, pins.we_n, pins.bit_input_oe}, 3'h6);
        @(posedge i_clk);
        i_rst <= 1'b0;
        t_pwrup();
        t_rw();
        t_mil();
        t_ret();
        check("host timing", 16'(viol), 16'h0000);
        give_verdict();
    end

    // Hang guard well beyond the expected run
    initial begin
        #200000;
        bad_count++;
        $display("ERROR watchdog expected finish seen hang");
        give_verdict();
    end
endmodule : tb_top
`default_nettype wire
